/* File: design/hpa_top.sv */
// Host port adapter: register file bridge, DMA engine and event flags
//
// Summary of operation
// - Present DMA address, step unless inhibited
// - Bursts 1-16 words, yield to others
// - No other requester: keep bus, continue
// - Data path tied to one port
// - Host interrupt only from microprocessor, gated
// - Errors set flags and summary event
// - Sticky event flags cleared by microprocessor
// - DMA address readable by microprocessor only
// - Multiplexed file, holding and address regs
// - Two-bit port select register
// - Direction zero loads both holding bytes (low only for 8-bit hosts)
// - Direction one stores holding bytes
// - Tie-break serves one side then other
// - Each file access under 100 ns
// - Byte-wide file access for 8-bit hosts
// - Answer only own switch address
// - Power-low status and abort at sector
// - Drive power loss posted in file
// - Host power-low flags, aborts running transfer
// - Reset clears registers
// - Master clear: flag, status to ready only
// - Programmed reset clears ready, interrupts
// - Strobe on trailing edge of phase two
`timescale 1ns/100ps
`default_nettype none
module hpa_top
  import hpa_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic [1:0]      port_addr_sw_i,
  input  wire logic            host8_i,
  input  wire logic            mp_phi2_i,
  input  wire logic            mp_vma_i,
  input  wire logic            mp_rw_i,
  input  wire logic [3:0]      mp_addr_i,
  input  wire logic [7:0]      mp_data_i,
  output logic [7:0]           mp_data_o,
  output logic                 mp_data_oe_o,
  output logic                 mpu_irq_o,
  input  wire logic            host_req_i,
  input  wire logic            host_we_i,
  input  wire logic [FA_W-1:0] host_addr_i,
  input  wire logic [DW-1:0]   host_wdata_i,
  output logic                 host_ack_o,
  output logic [DW-1:0]        host_rdata_o,
  output logic                 host_irq_o,
  output logic [7:0]           host_vec_o,
  input  wire logic            host_iack_i,
  input  wire logic            host_mclr_i,
  input  wire logic            host_prst_i,
  input  wire logic            host_pwrl_i,
  output logic                 dma_req_o,
  input  wire logic            dma_grant_i,
  input  wire logic            dma_other_i,
  output logic                 dma_wstb_o,
  input  wire logic            dma_ack_i,
  input  wire logic            dma_nxm_i,
  output logic [AW-1:0]        dma_addr_o,
  output logic [DW-1:0]        dma_data_o,
  input  wire logic            dbus_valid_i,
  input  wire logic [DW-1:0]   dbus_data_i,
  output logic                 dbus_ready_o,
  input  wire logic            sector_end_i
);
  hpa_st_t       s;
  hpa_st_t       n;
  logic          rf_mdone;
  logic          rf_hdone;
  logic [DW-1:0] rf_rdata;
  logic          strobe;
  logic          wr;
  logic          hit;
  logic          dp_hit;
  logic [7:0]    d;

  function automatic logic [7:0] lane(input logic [DW-1:0] w, input logic hi);
    lane = hi ? w[15:8] : w[7:0];
  endfunction

  function automatic logic rise(input logic x, input logic x_d);
    rise = x & ~x_d;
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  hpa_regfile #(
    .DEPTH (64)
  ) u_rf (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .m_req_i  (s.mreq),
    .h_req_i  (s.hreq),
    .m_done_o (rf_mdone),
    .h_done_o (rf_hdone),
    .rdata_o  (rf_rdata)
  );

  assign strobe = s.phi_d & ~s.mp2.phi2 & s.mp2.vma;
  assign wr     = strobe & ~s.mp2.rw;
  assign d      = s.mp2.data;
  assign hit    = (s.psel == s.sw);
  assign dp_hit = (s.ctrl[CT_DP +: 2] == s.sw);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] ev_set;
    logic [7:0] er_set;
    logic       irq_set;
    logic       mclr_r;
    logic       prst_r;
    logic       pwrl_r;
    logic       iack_r;
    ev_set  = '0;
    er_set  = '0;
    irq_set = 1'b0;
    n       = s;
    n.mp1   = {mp_phi2_i, mp_vma_i, mp_rw_i, mp_addr_i, mp_data_i};
    n.mp2   = s.mp1;
    n.phi_d = s.mp2.phi2;
    n.hin1  = {host_req_i, host_we_i, host_iack_i, host_mclr_i, host_prst_i, host_pwrl_i,
               dma_grant_i, dma_other_i, dma_ack_i, dma_nxm_i, host_addr_i, host_wdata_i};
    n.hin2  = s.hin1;
    n.edg_d = {s.hin2.iack, s.hin2.mclr, s.hin2.prst, s.hin2.pwrl};
    iack_r  = rise(s.hin2.iack, s.edg_d[3]);
    mclr_r  = rise(s.hin2.mclr, s.edg_d[2]);
    prst_r  = rise(s.hin2.prst, s.edg_d[1]);
    pwrl_r  = rise(s.hin2.pwrl, s.edg_d[0]);
    n.dready = 1'b0;

    if (rf_mdone) begin
      n.mreq.req = 1'b0;
      if (!s.mreq.we) begin
        if (s.host8) begin
          n.hl = lane(rf_rdata, s.fa[0]);
        end else begin
          n.hh = rf_rdata[15:8];
          n.hl = rf_rdata[7:0];
        end
      end
    end

    // Host side four-phase file access
    if (rf_hdone) begin
      n.hreq.req = 1'b0;
      n.hack     = 1'b1;
      n.hrdata   = rf_rdata;
      if (s.hreq.we && s.hreq.addr == CMD_LOC) begin
        ev_set[EV_CMD] = 1'b1;
      end
    end else if (s.hin2.req && !s.hack && !s.hreq.req) begin
      n.hreq = {1'b1, s.hin2.we, 2'b11, s.hin2.addr, s.hin2.wdata};
    end
    if (!s.hin2.req) begin
      n.hack = 1'b0;
    end

    if (iack_r) begin
      n.irq_pend = 1'b0;
    end

    // ****************************************
    // Microprocessor writes
    // ****************************************
    // Port select always written
    if (wr && s.mp2.addr == MA_PSEL) begin
      n.psel = d[1:0];
    end
    if (wr && hit) begin
      unique case (s.mp2.addr)
        MA_HOLD_HI: n.hh = d;
        MA_HOLD_LO: n.hl = d;
        MA_FADDR: begin
          n.fa         = d;
          n.mreq.req   = 1'b1;
          n.mreq.we    = d[FA_DIR];
          n.mreq.addr  = s.host8 ? {1'b0, d[FA_W-1:1]} : d[FA_W-1:0];
          n.mreq.be    = s.host8 ? {d[0], ~d[0]} : 2'b11;
          n.mreq.wdata = s.host8 ? {s.hl, s.hl} : {s.hh, s.hl};
        end
        MA_PSEL: ;
        MA_DMA_LO: n.dma_addr[7:0] = d;
        MA_DMA_HI: n.dma_addr[15:8] = d;
        MA_ERR:    n.err = s.err & ~d;
        MA_EVT:    n.evt = s.evt & ~d;
        MA_CTRL: begin
          n.ctrl         = d;
          n.ctrl[CT_IRQ] = 1'b0;
          n.ctrl[CT_ABT] = 1'b0;
          irq_set = d[CT_IRQ];
          if (d[CT_ABT]) begin
            n.abort_pend = 1'b1;
          end
        end
        MA_STAT:  n.stat = d;
        MA_VEC:   n.vec = d;
        MA_BURST: n.blen = d[BL_W-1:0];
        default:  ;
      endcase
    end
    if (irq_set) begin
      n.irq_pend = 1'b1;
    end

    // ****************************************
    // Host reset and power events
    // ****************************************
    // Master clear leaves ready
    if (mclr_r) begin
      ev_set[EV_MCLR] = 1'b1;
      n.stat          = STAT_MCL;
    end
    if (prst_r) begin
      ev_set[EV_PRST] = 1'b1;
      n.stat          = STAT_RST;
    end
    if (pwrl_r) begin
      ev_set[EV_PWRL] = 1'b1;
      if (s.ctrl[CT_RUN]) begin
        n.abort_pend = 1'b1;
      end
    end
    if (s.abort_pend && sector_end_i) begin
      n.abort_pend   = 1'b0;
      n.ctrl[CT_RUN] = 1'b0;
      ev_set[EV_DONE] = 1'b1;
    end

    // ****************************************
    // DMA engine
    // ****************************************
    n.tmo = '0;
    unique case (s.dst)
      D_IDLE: begin
        if (s.ctrl[CT_RUN] && dp_hit && dbus_valid_i) begin
          n.dreq = 1'b1;
          n.bcnt = '0;
          n.dst  = D_XFER;
        end
      end
      D_XFER: begin
        if (!n.ctrl[CT_RUN]) begin
          n.dst = D_REL;
        end else if (s.hin2.grant && !s.hin2.ack) begin
          if (dbus_valid_i) begin
            n.dma_data = dbus_data_i;
            n.dready   = 1'b1;
            n.wstb     = 1'b1;
            n.dst      = D_WAIT;
          end else begin
            n.dst = D_REL;
          end
        end
      end
      D_WAIT: begin
        n.tmo = TMO_W'(s.tmo + 1'b1);
        if (s.hin2.nxm) begin
          n.wstb         = 1'b0;
          er_set[ER_NXM] = 1'b1;
          n.ctrl[CT_RUN] = 1'b0;
          n.dst          = D_REL;
        end else if (s.hin2.ack) begin
          n.wstb = 1'b0;
          if (!s.ctrl[CT_INH]) begin
            n.dma_addr = AW'(s.dma_addr + 1'b1);
          end
          n.bcnt = BL_W'(s.bcnt + 1'b1);
          n.dst  = D_XFER;
          if (s.bcnt == s.blen) begin
            n.bcnt = '0;
            if (s.hin2.other) begin
              n.dst = D_REL;
            end
          end
        end else if (s.tmo == TMO_LAST) begin
          n.wstb         = 1'b0;
          er_set[ER_TMO] = 1'b1;
          n.ctrl[CT_RUN] = 1'b0;
          n.dst          = D_REL;
        end
      end
      D_REL: begin
        // Re-request only after grant seen gone
        n.dreq = 1'b0;
        n.dst  = s.hin2.grant ? D_REL : D_IDLE;
      end
    endcase

    n.err          = n.err | er_set;
    ev_set[EV_ERR] = |n.err;
    n.evt          = n.evt | ev_set;

    n.host_irq = s.irq_pend & s.ctrl[CT_IEN];
    n.mpu_irq  = s.evt[EV_MCLR] | s.evt[EV_PRST];

    // ****************************************
    // Microprocessor read path
    // ****************************************
    n.mdoe = s.mp2.phi2 & s.mp2.vma & s.mp2.rw & hit;
    unique case (s.mp2.addr)
      MA_HOLD_HI: n.mdo = s.hh;
      MA_HOLD_LO: n.mdo = s.hl;
      MA_FADDR:   n.mdo = s.fa;
      MA_PSEL:    n.mdo = {6'h00, s.psel};
      MA_DMA_LO:  n.mdo = s.dma_addr[7:0];
      MA_DMA_HI:  n.mdo = s.dma_addr[15:8];
      MA_ERR:     n.mdo = s.err;
      MA_EVT:     n.mdo = s.evt;
      MA_CTRL:    n.mdo = s.ctrl;
      MA_STAT:    n.mdo = s.stat;
      MA_VEC:     n.mdo = s.vec;
      MA_BURST:   n.mdo = {4'h0, s.blen};
      default:    n.mdo = 8'h00;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset clears all state; switch address and host width load from pins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s       <= '0;
      s.sw    <= port_addr_sw_i;
      s.host8 <= host8_i;
      s.stat  <= STAT_RST;
    end else begin
      s <= n;
    end
  end

  assign mp_data_o    = s.mdo;
  assign mp_data_oe_o = s.mdoe;
  assign mpu_irq_o    = s.mpu_irq;
  assign host_ack_o   = s.hack;
  assign host_rdata_o = s.hrdata;
  assign host_irq_o   = s.host_irq;
  assign host_vec_o   = s.vec;
  assign dma_req_o    = s.dreq;
  assign dma_wstb_o   = s.wstb;
  assign dma_addr_o   = s.dma_addr;
  assign dma_data_o   = s.dma_data;
  assign dbus_ready_o = s.dready;
endmodule
`default_nettype wire

/* File: design/hpa_pkg.sv */
// Shared constants and types for the host port adapter
package hpa_pkg;
  localparam int unsigned CLK_NS  = 20;
  localparam int unsigned TMO_NS  = 10000;
  localparam int unsigned TMO_CYC = TMO_NS / CLK_NS;
  localparam int unsigned TMO_W   = $clog2(TMO_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYC - 1);
  localparam int unsigned ACC_NS  = 100;
  localparam int unsigned ACC_CYC = ACC_NS / CLK_NS;
  localparam int unsigned FA_W    = 6;
  localparam int unsigned DW      = 16;
  localparam int unsigned AW      = 16;
  localparam int unsigned BL_W    = 4;

  // Adapter offsets on the microprocessor bus
  localparam logic [3:0] MA_HOLD_HI = 4'h0;
  localparam logic [3:0] MA_HOLD_LO = 4'h1;
  localparam logic [3:0] MA_FADDR   = 4'h2;
  localparam logic [3:0] MA_PSEL    = 4'h3;
  localparam logic [3:0] MA_DMA_LO  = 4'h4;
  localparam logic [3:0] MA_DMA_HI  = 4'h5;
  localparam logic [3:0] MA_ERR     = 4'h6;
  localparam logic [3:0] MA_EVT     = 4'h7;
  localparam logic [3:0] MA_CTRL    = 4'h8;
  localparam logic [3:0] MA_STAT    = 4'h9;
  localparam logic [3:0] MA_VEC     = 4'ha;
  localparam logic [3:0] MA_BURST   = 4'hb;

  localparam int FA_DIR  = 7;
  localparam int CT_RUN  = 0;
  localparam int CT_INH  = 1;
  localparam int CT_IEN  = 2;
  localparam int CT_IRQ  = 3;
  localparam int CT_DP   = 4;
  localparam int CT_ABT  = 6;
  localparam int ST_RDY  = 0;
  localparam int ST_PWRL = 1;
  localparam int ER_TMO  = 0;
  localparam int ER_NXM  = 1;
  localparam int EV_ERR  = 0;
  localparam int EV_MCLR = 1;
  localparam int EV_PRST = 2;
  localparam int EV_PWRL = 3;
  localparam int EV_CMD  = 4;
  localparam int EV_DONE = 5;
  localparam logic [FA_W-1:0] CMD_LOC  = 6'h00;
  localparam logic [7:0]      STAT_RST = 8'h00;
  localparam logic [7:0]      STAT_MCL = 8'h01;

  typedef struct packed {
    logic            req;
    logic            we;
    logic [1:0]      be;
    logic [FA_W-1:0] addr;
    logic [DW-1:0]   wdata;
  } hpa_freq_t;

  typedef struct packed {
    logic       phi2;
    logic       vma;
    logic       rw;
    logic [3:0] addr;
    logic [7:0] data;
  } hpa_mpin_t;

  typedef struct packed {
    logic            req;
    logic            we;
    logic            iack;
    logic            mclr;
    logic            prst;
    logic            pwrl;
    logic            grant;
    logic            other;
    logic            ack;
    logic            nxm;
    logic [FA_W-1:0] addr;
    logic [DW-1:0]   wdata;
  } hpa_hin_t;

  typedef enum logic [1:0] {D_IDLE, D_XFER, D_WAIT, D_REL} hpa_dst_t;

  typedef struct packed {
    logic          last_h;
    logic          m_done;
    logic          h_done;
    logic [DW-1:0] rdata;
  } hpa_rf_t;

  typedef struct packed {
    hpa_mpin_t       mp1;
    hpa_mpin_t       mp2;
    logic            phi_d;
    hpa_hin_t        hin1;
    hpa_hin_t        hin2;
    logic [3:0]      edg_d;
    logic [1:0]      sw;
    logic            host8;
    logic [1:0]      psel;
    logic [7:0]      hh;
    logic [7:0]      hl;
    logic [7:0]      fa;
    hpa_freq_t       mreq;
    hpa_freq_t       hreq;
    logic            hack;
    logic [DW-1:0]   hrdata;
    logic [7:0]      ctrl;
    logic [7:0]      stat;
    logic [7:0]      err;
    logic [7:0]      evt;
    logic [7:0]      vec;
    logic [BL_W-1:0] blen;
    logic [BL_W-1:0] bcnt;
    logic [AW-1:0]   dma_addr;
    logic [DW-1:0]   dma_data;
    logic            dreq;
    logic            wstb;
    logic            dready;
    hpa_dst_t        dst;
    logic [TMO_W-1:0] tmo;
    logic            abort_pend;
    logic            irq_pend;
    logic            host_irq;
    logic [7:0]      mdo;
    logic            mdoe;
    logic            mpu_irq;
  } hpa_st_t;
endpackage

/* File: design/hpa_regfile.sv */
// Shared register file RAM with two-sided tie-break arbitration
`timescale 1ns/100ps
`default_nettype none
module hpa_regfile
  import hpa_pkg::*;
#(
  parameter int unsigned DEPTH = 64
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire hpa_freq_t     m_req_i,
  input  wire hpa_freq_t     h_req_i,
  output logic               m_done_o,
  output logic               h_done_o,
  output logic [DW-1:0]      rdata_o
);
  hpa_rf_t       s;
  hpa_rf_t       n;
  logic [DW-1:0] mem [DEPTH];
  logic          m_ok;
  logic          gh;
  logic          gm;
  hpa_freq_t     sel;

  assign m_ok = m_req_i.req & ~s.m_done;
  assign gh   = h_req_i.req & ~s.h_done & (~m_ok | ~s.last_h);
  assign gm   = m_ok & ~gh;
  assign sel  = gh ? h_req_i : m_req_i;

  always_comb begin
    n        = s;
    n.h_done = gh;
    n.m_done = gm;
    if (gh | gm) begin
      n.last_h = gh;
      n.rdata  = mem[sel.addr];
    end
  end

  always_ff @(posedge clk_i) begin
    if ((gh | gm) && sel.we) begin
      if (sel.be[1]) begin
        mem[sel.addr][15:8] <= sel.wdata[15:8];
      end
      if (sel.be[0]) begin
        mem[sel.addr][7:0] <= sel.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign m_done_o = s.m_done;
  assign h_done_o = s.h_done;
  assign rdata_o  = s.rdata;
endmodule
`default_nettype wire

/* File: verif/hpa_host_dma_model.sv */
// Behavioural model of the host DMA bus arbiter and memory slave
`timescale 1ns/100ps
`default_nettype none
module hpa_host_dma_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic dma_req_i,
  input  wire logic dma_wstb_i,
  input  wire logic other_i,
  input  wire logic slow_i,
  input  wire logic mute_i,
  output logic      dma_grant_o,
  output logic      dma_other_o,
  output logic      dma_ack_o,
  output logic      dma_nxm_o
);
  logic [2:0] wait_q;

  assign dma_nxm_o = 1'b0;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dma_grant_o <= 1'b0;
      dma_other_o <= 1'b0;
      dma_ack_o   <= 1'b0;
      wait_q      <= 3'h0;
    end else begin
      dma_grant_o <= dma_req_i;
      dma_other_o <= other_i;
      if (!dma_wstb_i) begin
        dma_ack_o <= 1'b0;
        wait_q    <= slow_i ? 3'h5 : 3'h0;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end else if (dma_grant_o && !mute_i) begin
        dma_ack_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/hpa_top_chk.sv */
// Pin-level checker for the host port adapter
`timescale 1ns/100ps
`default_nettype none
module hpa_top_chk
  import hpa_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          mp_vma_i,
  input  wire logic          mp_rw_i,
  input  wire logic          mp_data_oe_o,
  input  wire logic          mpu_irq_o,
  input  wire logic          host_req_i,
  input  wire logic          host_ack_o,
  input  wire logic          host_irq_o,
  input  wire logic          host_mclr_i,
  input  wire logic          host_prst_i,
  input  wire logic          dma_req_o,
  input  wire logic          dma_grant_i,
  input  wire logic          dma_wstb_o,
  input  wire logic [AW-1:0] dma_addr_o,
  input  wire logic [DW-1:0] dma_data_o,
  input  wire logic          dbus_ready_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  rst_quiet_a: assert property (disable iff (1'b0)
    !rst_n_i |=> !dma_req_o && !host_ack_o && !mpu_irq_o && !host_irq_o && !mp_data_oe_o)
    else $error("outputs not idle after reset");
  ack_cause_a: assert property ($rose(host_ack_o) |-> $past(host_req_i, 3))
    else $error("host ack without request");
  ack_time_a: assert property ($rose(host_req_i) |-> ##[4:12] host_ack_o)
    else $error("host access too slow");
  ack_drop_a: assert property ($fell(host_req_i) |-> ##[1:6] !host_ack_o)
    else $error("host ack stuck");
  oe_cause_a: assert property ($rose(mp_data_oe_o) |-> $past(mp_vma_i, 2) && $past(mp_rw_i, 2))
    else $error("data driven without read cycle");
  strobe_grant_a: assert property ($rose(dma_wstb_o) |-> $past(dma_grant_i, 2) && dma_req_o)
    else $error("strobe without grant");
  strobe_hold_a: assert property (dma_wstb_o && $past(dma_wstb_o) |-> $stable(dma_addr_o) && $stable(dma_data_o))
    else $error("address or data moved under strobe");
  addr_step_a: assert property (dma_req_o && $past(dma_req_o) && $changed(dma_addr_o)
    |-> dma_addr_o == $past(dma_addr_o) + 16'h0001)
    else $error("address step not one word");
  strobe_tmo_a: assert property ($rose(dma_wstb_o) |-> ##[1:520] !dma_wstb_o)
    else $error("strobe not ended by timeout");
  word_take_a: assert property ($rose(dma_wstb_o) |-> dbus_ready_o ##1 !dbus_ready_o)
    else $error("data word not taken once");
  reset_irq_a: assert property ($rose(host_mclr_i) || $rose(host_prst_i) |-> ##[2:8] mpu_irq_o)
    else $error("no interrupt on host reset");
endmodule

bind hpa_top hpa_top_chk i_hpa_top_chk (.*);
`default_nettype wire

/* File: verif/hpa_top_tb.sv */
// Self-checking testbench for the host port adapter
`timescale 1ns/100ps
`default_nettype none
module hpa_top_tb;
  import hpa_pkg::*;
  logic            clk_i, rst_n_i, host8_i, mp_phi2_i, mp_vma_i, mp_rw_i, mp_data_oe_o, mpu_irq_o;
  logic            host_req_i, host_we_i, host_ack_o, host_irq_o, host_iack_i, host_mclr_i, host_prst_i;
  logic            host_pwrl_i, dma_req_o, dma_grant_i, dma_other_i, dma_wstb_o, dma_ack_i, dma_nxm_i;
  logic            dbus_valid_i, dbus_ready_o, sector_end_i, other_q, slow_q, mute_q, wstb_d, dropped;
  logic [1:0]      port_addr_sw_i;
  logic [3:0]      mp_addr_i;
  logic [7:0]      mp_data_i, mp_data_o, host_vec_o, rd;
  logic [FA_W-1:0] host_addr_i;
  logic [DW-1:0]   host_wdata_i, host_rdata_o, dma_data_o, dbus_data_i, hw;
  logic [AW-1:0]   dma_addr_o;
  logic [19:0]     rows [10];
  int              errors, comparisons, cyc, ns, nw, mode, n;

  hpa_top i_hpa_top (.*);
  hpa_host_dma_model i_hpa_host_dma_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .dma_req_i(dma_req_o),
    .dma_wstb_i(dma_wstb_o), .other_i(other_q), .slow_i(slow_q), .mute_i(mute_q), .dma_grant_o(dma_grant_i),
    .dma_other_o(dma_other_i), .dma_ack_o(dma_ack_i), .dma_nxm_o(dma_nxm_i));

  always #10 clk_i = ~clk_i;

  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One microprocessor bus cycle; read data lands in rd, zero if not driven
  task automatic mp(input logic rw, input logic [3:0] a, input logic [7:0] wd);
    @(posedge clk_i);
    mp_vma_i  <= 1'b1;
    mp_rw_i   <= rw;
    mp_addr_i <= a;
    mp_data_i <= wd;
    @(posedge clk_i);
    mp_phi2_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd = mp_data_oe_o ? mp_data_o : 8'h00;
    mp_phi2_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    mp_vma_i <= 1'b0;
  endtask

  task automatic host(input logic we, input logic [5:0] a, input logic [15:0] wd);
    int k;
    @(posedge clk_i);
    host_req_i   <= 1'b1;
    host_we_i    <= we;
    host_addr_i  <= a;
    host_wdata_i <= wd;
    for (k = 0; k < 30 && host_ack_o !== 1'b1; k++) @(posedge clk_i);
    hw = host_rdata_o;
    host_req_i <= 1'b0;
    for (k = 0; k < 30 && host_ack_o !== 1'b0; k++) @(posedge clk_i);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    {host_pwrl_i, host_prst_i, host_mclr_i, host_iack_i} <= 4'h1 << i;
    repeat (4) @(posedge clk_i);
    {host_pwrl_i, host_prst_i, host_mclr_i, host_iack_i} <= 4'h0;
    repeat (6) @(posedge clk_i);
  endtask

  // Timeout and DMA stream monitor
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    wstb_d <= dma_wstb_o;
    if (!dma_req_o) dropped <= 1'b1;
    if (dbus_ready_o) begin
      dbus_data_i <= dbus_data_i + 16'h0001;
      if (nw == 3) dbus_valid_i <= 1'b0;
      nw <= nw + 1;
    end
    if (dma_wstb_o && !wstb_d && mode < 2) begin
      check("dma address", 16'h0010 + (mode == 1 ? 16'h0000 : 16'(ns)), dma_addr_o);
      check("dma data", 16'h1000 + 16'(ns), dma_data_o);
      if (ns > 0) check("bus release", {15'h0, ns == 2 && mode == 0}, {15'h0, dropped});
      ns <= ns + 1;
      dropped <= 1'b0;
    end
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
  end

  // ***********************************
  // Main sequence
  // ***********************************
  initial begin
    {clk_i, rst_n_i, host8_i, mp_phi2_i, mp_vma_i, mp_rw_i, host_req_i, host_we_i} = 8'h00;
    {host_iack_i, host_mclr_i, host_prst_i, host_pwrl_i, dbus_valid_i, sector_end_i} = 6'h00;
    {other_q, slow_q, mute_q, wstb_d, dropped} = 5'h00;
    {mp_addr_i, mp_data_i, host_addr_i, host_wdata_i, dbus_data_i} = '0;
    port_addr_sw_i = 2'h2;
    {errors, comparisons, cyc, ns, nw, mode} = '0;
    rows = '{{MA_HOLD_HI, 8'ha5, 8'ha5}, {MA_HOLD_LO, 8'h5a, 8'h5a}, {MA_VEC, 8'h3c, 8'h3c},
             {MA_BURST, 8'h01, 8'h01}, {MA_DMA_LO, 8'h10, 8'h10}, {MA_DMA_HI, 8'h00, 8'h00},
             {MA_CTRL, 8'h4a, 8'h02}, {MA_ERR, 8'hff, 8'h00}, {4'hc, 8'hff, 8'h00}, {4'hf, 8'hff, 8'h00}};
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    mp(0, MA_PSEL, 8'h01);
    mp(0, MA_VEC, 8'h99);
    mp(0, MA_PSEL, 8'h02);
    mp(1, MA_VEC, 8'h00);
    check("foreign port write", 8'h00, rd);
    for (int i = 0; i < 10; i++) begin
      mp(0, rows[i][19:16], rows[i][15:8]);
      mp(1, rows[i][19:16], 8'h00);
      check("register readback", rows[i][7:0], rd);
    end
    $display("register table done");
    check("irq held while disabled", 1'b0, host_irq_o);
    mp(0, MA_CTRL, 8'h04);
    repeat (4) @(posedge clk_i);
    check("irq after enable", 1'b1, host_irq_o);
    check("vector", 8'h3c, host_vec_o);
    pulse(0);
    check("irq after ack", 1'b0, host_irq_o);
    $display("interrupt test done");
    mp(0, MA_HOLD_HI, 8'h12);
    mp(0, MA_HOLD_LO, 8'h34);
    mp(0, MA_FADDR, 8'h85);
    host(0, 6'h05, 16'h0000);
    check("file write", 16'h1234, hw);
    host(1, 6'h06, 16'hbeef);
    mp(0, MA_FADDR, 8'h06);
    mp(1, MA_HOLD_HI, 8'h00);
    check("file read high", 8'hbe, rd);
    mp(1, MA_HOLD_LO, 8'h00);
    check("file read low", 8'hef, rd);
    // Host request reaches the file in the same cycle as the store
    fork
      mp(0, MA_FADDR, 8'h88);
      begin
        repeat (9) @(posedge clk_i);
        host(1, 6'h07, 16'h5555);
      end
    join
    host(0, 6'h08, 16'h0000);
    check("contended mpu store", 16'hbeef, hw);
    host(0, 6'h07, 16'h0000);
    check("contended host store", 16'h5555, hw);
    host(1, CMD_LOC, 16'h0001);
    mp(1, MA_EVT, 8'h00);
    check("command flag", 8'h10, rd & 8'h10);
    mp(0, MA_EVT, 8'h10);
    mp(1, MA_EVT, 8'h00);
    check("command flag cleared", 8'h00, rd & 8'h10);
    $display("file test done");
    for (int i = 1; i < 4; i++) begin
      pulse(i);
      check("mpu interrupt", {15'h0, i < 3}, {15'h0, mpu_irq_o});
      mp(1, MA_EVT, 8'h00);
      check("event flag", 8'h01 << i, rd);
      mp(1, MA_STAT, 8'h00);
      check("status", i == 1 ? STAT_MCL : STAT_RST, rd);
      mp(0, MA_EVT, 8'hff);
    end
    $display("event test done");
    for (int m = 0; m < 2; m++) begin
      other_q <= (m == 0);
      slow_q  <= (m == 1);
      mp(0, MA_DMA_LO, 8'h10);
      mp(0, MA_DMA_HI, 8'h00);
      mode = m;
      ns   = 0;
      nw   = 0;
      dbus_data_i  <= 16'h1000;
      dbus_valid_i <= 1'b1;
      mp(0, MA_CTRL, m == 1 ? 8'h23 : 8'h21);
      for (n = 0; n < 3000 && ns < 4; n++) @(posedge clk_i);
      check("dma words", 16'h4, 16'(ns));
      mp(0, MA_CTRL, 8'h20);
    end
    $display("dma test done");
    mode = 2;
    mute_q <= 1'b1;
    dbus_valid_i <= 1'b1;
    mp(0, MA_CTRL, 8'h21);
    for (n = 0; n < 700 && !(wstb_d && !dma_wstb_o); n++) @(posedge clk_i);
    mp(1, MA_ERR, 8'h00);
    check("timeout error", 8'h01, rd & 8'h01);
    mp(1, MA_EVT, 8'h00);
    check("error summary", 8'h01, rd & 8'h01);
    {mute_q, dbus_valid_i} <= 2'b00;
    $display("timeout test done");
    rst_n_i <= 1'b0;
    host8_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check("outputs in reset", 4'h0, {host_irq_o, dma_req_o, mpu_irq_o, mp_data_oe_o});
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    mp(0, MA_PSEL, 8'h02);
    mp(1, MA_STAT, 8'h00);
    check("status after reset", 8'h00, rd);
    $display("reset test done");
    mp(0, MA_HOLD_LO, 8'h77);
    mp(0, MA_FADDR, 8'h83);
    host(0, 6'h01, 16'h0000);
    check("byte lane store", 8'h77, hw[15:8]);
    host(1, 6'h02, 16'h3cc3);
    mp(0, MA_FADDR, 8'h05);
    mp(1, MA_HOLD_LO, 8'h00);
    check("byte lane fetch", 8'h3c, rd);
    mp(0, MA_CTRL, 8'h61);
    mp(1, MA_CTRL, 8'h00);
    check("run before sector end", 8'h21, rd);
    sector_end_i <= 1'b1;
    @(posedge clk_i);
    sector_end_i <= 1'b0;
    mp(1, MA_CTRL, 8'h00);
    check("abort at sector end", 8'h20, rd);
    $display("byte and abort test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
